// ==== hw/rde_ctrl.sv ====
// Purpose: driver enable, cts handshake, turnaround and routing of a serial line converter
// Assumes: all line inputs synchronous to pclk; settings written over APB
// Notes: every output is a flip-flop; each reacts one cycle after its cause, but cts rise outside the always-on setting and start-bit enable take two
//
// Overview of operation
// - role bit picks terminal-side or modem-side behaviour for cts and enable
// - modem side raises cts 0, 10 or 30 ms after rts rises
// - cts drops at once when rts drops, whatever delay
// - always-on setting makes cts a plain copy of rts on modem side
// - carrier inhibit holds cts low if carrier present when rts rises
// - terminal side never drives cts high
// - lead enabling needs lead source and a 0/10/30 ms setting
// - terminal side lead enabling follows the cd input
// - modem side lead enabling follows the rts input
// - data enabling turns driver on at first start bit and arms timer
// - each low to high data edge restarts the idle timer
// - timer expiry turns the driver off; five timeout choices
// - always-on setting keeps the driver on permanently
// - always-on with lead source stays on, no half duplex possible
// - duplex bit picks two-wire half or four-wire full duplex
// - half duplex waits a turnaround delay before receiving again
// - turnaround choices are 0, 0.1, 1, 5 and 35 ms
// - normal mode passes rs232 to rs485 and back
// - loopback returns each port's received data out of the same port
// - line bias makes the carrier read as always present
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module rde_ctrl #(
    parameter int unsigned CTS_10_CYC = rde_pkg::CTS_10_CYC,
    parameter int unsigned CTS_30_CYC = rde_pkg::CTS_30_CYC,
    parameter int unsigned IDLE_A_CYC = rde_pkg::IDLE_A_CYC,
    parameter int unsigned IDLE_B_CYC = rde_pkg::IDLE_B_CYC,
    parameter int unsigned IDLE_C_CYC = rde_pkg::IDLE_C_CYC,
    parameter int unsigned IDLE_D_CYC = rde_pkg::IDLE_D_CYC,
    parameter int unsigned IDLE_E_CYC = rde_pkg::IDLE_E_CYC,
    parameter int unsigned TURN_B_CYC = rde_pkg::TURN_B_CYC,
    parameter int unsigned TURN_C_CYC = rde_pkg::TURN_C_CYC,
    parameter int unsigned TURN_D_CYC = rde_pkg::TURN_D_CYC,
    parameter int unsigned TURN_E_CYC = rde_pkg::TURN_E_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rde_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rs232_rxd,
    input wire logic rts_in,
    input wire logic cd_in,
    input wire logic rs485_rxd,
    input wire logic rs485_carrier,
    output logic rs232_txd,
    output logic cts_out,
    output logic rs485_txd,
    output logic rs485_de,
    output logic rs485_re_n
);
    localparam int CW = rde_pkg::CNT_W;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic [rde_pkg::CFG_W-1:0] cfg_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [rde_pkg::STAT_W-1:0] stat_w;
    wire hit_cfg = (paddr == rde_pkg::ADDR_CFG);
    wire hit_stat = (paddr == rde_pkg::ADDR_STAT);
    wire unmapped = !(hit_cfg || hit_stat);
    wire setup_end = psel && penable && !pready_reg;
    wire done = psel && penable && pready_reg;
    wire cfg_wr = done && pwrite && hit_cfg;
    wire [31:0] rd_val = hit_cfg ? {{(32-rde_pkg::CFG_W){1'b0}}, cfg_reg} :
                         hit_stat ? {{(32-rde_pkg::STAT_W){1'b0}}, stat_w} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            cfg_reg <= rde_pkg::CFG_RST;
        end
        else
        begin
            pready_reg <= setup_end;
            pslverr_reg <= setup_end && unmapped;
            if (setup_end && !pwrite)
                prdata_reg <= rd_val;
            if (cfg_wr)
                cfg_reg <= pwdata[rde_pkg::CFG_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    wire modem = cfg_reg[rde_pkg::CFG_ROLE];
    wire [1:0] cts_sel = cfg_reg[rde_pkg::CFG_CTS_LO +: 2];
    wire src_data = cfg_reg[rde_pkg::CFG_SRC];
    wire [2:0] idle_sel = cfg_reg[rde_pkg::CFG_IDLE_LO +: 3];
    wire [2:0] turn_sel = cfg_reg[rde_pkg::CFG_TURN_LO +: 3];
    wire half = cfg_reg[rde_pkg::CFG_DUPLEX];
    wire inhib_sel = cfg_reg[rde_pkg::CFG_INHIB];
    wire loopback = cfg_reg[rde_pkg::CFG_LOOP];
    wire bias = cfg_reg[rde_pkg::CFG_BIAS];
    wire always_on = (cts_sel == rde_pkg::CTS_SEL_ON);
    wire carrier = rs485_carrier || bias;
    // selector codes above e read as e
    wire [CW-1:0] cts_dly = (cts_sel == rde_pkg::CTS_SEL_10) ? CW'(CTS_10_CYC) :
                            (cts_sel == rde_pkg::CTS_SEL_30) ? CW'(CTS_30_CYC) : '0;
    wire [CW-1:0] idle_dly = (idle_sel == 3'h0) ? CW'(IDLE_A_CYC) :
                             (idle_sel == 3'h1) ? CW'(IDLE_B_CYC) :
                             (idle_sel == 3'h2) ? CW'(IDLE_C_CYC) :
                             (idle_sel == 3'h3) ? CW'(IDLE_D_CYC) : CW'(IDLE_E_CYC);
    wire [CW-1:0] turn_dly = (turn_sel == 3'h0) ? '0 :
                             (turn_sel == 3'h1) ? CW'(TURN_B_CYC) :
                             (turn_sel == 3'h2) ? CW'(TURN_C_CYC) :
                             (turn_sel == 3'h3) ? CW'(TURN_D_CYC) : CW'(TURN_E_CYC);

    // ------------------------------------------------------------
    // cts handshake
    // ------------------------------------------------------------
    logic rts_d_reg;
    logic inh_reg;
    logic cts_reg;
    logic [CW-1:0] cts_cnt_reg;
    wire rts_rise = rts_in && !rts_d_reg;
    wire inh_now = rts_rise ? (inhib_sel && carrier) : inh_reg;
    wire [CW-1:0] cts_cnt_next = rts_rise ? cts_dly :
                                 (cts_cnt_reg != '0) ? cts_cnt_reg - CW'(1) : cts_cnt_reg;
    wire cts_delayed = rts_in && !inh_now && !rts_rise && (cts_cnt_reg == '0);
    wire cts_next = !modem ? 1'b0 :
                    always_on ? rts_in : cts_delayed;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rts_d_reg <= 1'b0;
            inh_reg <= 1'b0;
            cts_reg <= 1'b0;
            cts_cnt_reg <= '0;
        end
        else
        begin
            rts_d_reg <= rts_in;
            inh_reg <= inh_now;
            cts_reg <= cts_next;
            cts_cnt_reg <= cts_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // data-driven enable with idle timer
    // ------------------------------------------------------------
    logic rxd_d_reg;
    logic act_reg;
    logic [CW-1:0] idle_cnt_reg;
    wire rxd_rise = rs232_rxd && !rxd_d_reg;
    wire act_next = !rs232_rxd ? 1'b1 :
                    rxd_rise ? 1'b1 :
                    (act_reg && idle_cnt_reg == '0) ? 1'b0 : act_reg;
    wire [CW-1:0] idle_cnt_next = rxd_rise ? idle_dly :
                                  (idle_cnt_reg != '0) ? idle_cnt_reg - CW'(1) : idle_cnt_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxd_d_reg <= 1'b1;
            act_reg <= 1'b0;
            idle_cnt_reg <= '0;
        end
        else
        begin
            rxd_d_reg <= rs232_rxd;
            act_reg <= act_next;
            idle_cnt_reg <= idle_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // driver enable, turnaround and routing
    // ------------------------------------------------------------
    logic de_reg;
    logic re_n_reg;
    logic [CW-1:0] turn_cnt_reg;
    logic txd485_reg;
    logic txd232_reg;
    wire lead_en = modem ? rts_in : cd_in;
    wire de_next = always_on ? 1'b1 :
                   !src_data ? lead_en : act_reg;
    wire de_fall = de_reg && !de_next;
    wire [CW-1:0] turn_cnt_next = (half && de_fall) ? turn_dly :
                                  (turn_cnt_reg != '0) ? turn_cnt_reg - CW'(1) : turn_cnt_reg;
    wire re_n_next = half && (de_next || turn_cnt_next != '0);
    wire txd485_next = loopback ? rs485_rxd : rs232_rxd;
    wire txd232_next = loopback ? rs232_rxd : rs485_rxd;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            de_reg <= 1'b0;
            re_n_reg <= 1'b0;
            turn_cnt_reg <= '0;
            txd485_reg <= 1'b1;
            txd232_reg <= 1'b1;
        end
        else
        begin
            de_reg <= de_next;
            re_n_reg <= re_n_next;
            turn_cnt_reg <= turn_cnt_next;
            txd485_reg <= txd485_next;
            txd232_reg <= txd232_next;
        end
    end

    assign stat_w = {cd_in, rts_in, carrier, act_reg, re_n_reg, de_reg, cts_reg};
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign rs232_txd = txd232_reg;
    assign cts_out = cts_reg;
    assign rs485_txd = txd485_reg;
    assign rs485_de = de_reg;
    assign rs485_re_n = re_n_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cts_drop_fast: assert property (modem && !rts_in |=> !cts_reg)
        else $error("cts stayed high after rts fell");
    a_cts_copy_on: assert property (modem && always_on |=> cts_reg == $past(rts_in))
        else $error("cts not a copy of rts in always-on setting");
    a_cts_zero_delay: assert property (modem && cts_sel == 2'h0 && !inhib_sel && $rose(rts_in)
        ##1 rts_in |=> cts_reg)
        else $error("cts late with zero delay");
    a_cts_inhibit: assert property (modem && !always_on && inhib_sel && carrier && rts_rise
        ##1 (rts_in && !always_on)[*3] |-> !cts_reg)
        else $error("cts raised despite carrier");
    a_cts_terminal: assert property (!modem |=> !cts_reg)
        else $error("cts driven in terminal role");
    a_de_always_on: assert property (always_on |=> de_reg)
        else $error("driver off in always-on setting");
    a_de_lead_role: assert property (!always_on && !src_data |=> de_reg == $past(lead_en))
        else $error("driver enable not following control lead");
    a_de_data_start: assert property (!always_on && src_data && !rs232_rxd ##1 1'b1 |=> de_reg)
        else $error("driver not enabled by start bit");
    a_rx_full: assert property (!half |=> !re_n_reg)
        else $error("receiver disabled in full duplex");
    a_rx_while_tx: assert property (half && de_next |=> re_n_reg)
        else $error("receiver enabled while transmitting half duplex");
    a_route_loop: assert property (loopback |=> rs485_txd == $past(rs485_rxd)
        && rs232_txd == $past(rs232_rxd))
        else $error("loopback routing wrong");
    a_route_norm: assert property (!loopback |=> rs485_txd == $past(rs232_rxd)
        && rs232_txd == $past(rs485_rxd))
        else $error("normal routing wrong");

    c_cts_delayed: cover property (modem && !always_on && cts_sel != 2'h0 && $rose(cts_reg));
    c_data_timeout: cover property (src_data && !always_on && $fell(de_reg));
    c_turnaround: cover property (half && $fell(de_reg) ##1 re_n_reg ##[1:50] !re_n_reg);
    c_cfg_write: cover property (cfg_wr);
    c_loop_half: cover property (loopback && half && re_n_reg);

    // ------------------------------------------------------------
    // handshake timer checks
    // ------------------------------------------------------------
    a_cts_low_rise: assert property (
        modem && !always_on && rts_rise
        |=> !cts_reg)
        else $error("cts high in the cycle after rts rise");

    a_cts_cnt_load: assert property (
        rts_rise
        |=> cts_cnt_reg == $past(cts_dly))
        else $error("cts counter not reloaded on rts rise");

    a_cts_hold_dly: assert property (
        modem && !always_on && cts_cnt_reg != '0
        |=> !cts_reg)
        else $error("cts raised before delay ran out");

    a_inh_latch: assert property (
        !rts_rise
        |=> inh_reg == $past(inh_reg))
        else $error("inhibit changed without rts rise");

    a_cts_inh_hold: assert property (
        modem && !always_on && inh_reg && !rts_rise
        |=> !cts_reg)
        else $error("cts raised while inhibited");

    a_cts_term_on: assert property (
        !modem && always_on
        |=> !cts_reg)
        else $error("cts driven in terminal role");

    a_de_rts_off: assert property (
        modem && !always_on && !src_data && !rts_in
        |=> !de_reg)
        else $error("driver on without rts");

    a_de_cd_term: assert property (
        !modem && !always_on && !src_data
        |=> de_reg == $past(cd_in))
        else $error("terminal driver not following cd");

    // ------------------------------------------------------------
    // data timer and turnaround checks
    // ------------------------------------------------------------
    a_de_data_src: assert property (
        !always_on && src_data
        |=> de_reg == $past(act_reg))
        else $error("data source driver enable wrong");

    a_act_start: assert property (
        !rs232_rxd
        |=> act_reg)
        else $error("start bit did not arm activity");

    a_idle_reload: assert property (
        rxd_rise
        |=> idle_cnt_reg == $past(idle_dly))
        else $error("idle timer not reloaded on rise");

    a_idle_expire: assert property (
        act_reg && idle_cnt_reg == '0 && rs232_rxd && !rxd_rise
        |=> !act_reg)
        else $error("activity kept after timeout");

    a_de_on_data: assert property (
        always_on && src_data
        |=> de_reg)
        else $error("driver off in always-on setting");

    a_on_half_tx: assert property (
        always_on && half
        |=> re_n_reg)
        else $error("receiver on with driver always on");

    a_turn_load: assert property (
        half && de_fall
        |=> turn_cnt_reg == $past(turn_dly))
        else $error("turnaround not loaded at driver off");

    a_rx_turn_hold: assert property (
        half && turn_cnt_next != '0
        |=> re_n_reg)
        else $error("receiver on during turnaround");

    a_rx_turn_end: assert property (
        half && !de_next && turn_cnt_next == '0
        |=> !re_n_reg)
        else $error("receiver off after turnaround");

    a_cts_on_copy: assert property (
        modem && always_on && rts_in
        |=> cts_reg)
        else $error("cts not following rts");
endmodule : rde_ctrl

// ==== hw/rde_pkg.sv ====
// Purpose: shared constants of the line-driver enable controller
// Assumes: 250 MHz clock, APB register access
// Notes: times kept in microseconds, cycle counts derived from them
package rde_pkg;
    // ------------------------------------------------------------
    // clock and counters
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int CNT_W = 25;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam int CFG_W = 14;
    localparam logic [13:0] CFG_RST = 14'h0000;
    localparam int CFG_ROLE = 0;
    localparam int CFG_CTS_LO = 1;
    localparam int CFG_SRC = 3;
    localparam int CFG_IDLE_LO = 4;
    localparam int CFG_TURN_LO = 7;
    localparam int CFG_DUPLEX = 10;
    localparam int CFG_INHIB = 11;
    localparam int CFG_LOOP = 12;
    localparam int CFG_BIAS = 13;
    localparam int STAT_W = 7;
    localparam logic [1:0] CTS_SEL_10 = 2'h1;
    localparam logic [1:0] CTS_SEL_30 = 2'h2;
    localparam logic [1:0] CTS_SEL_ON = 2'h3;
    // ------------------------------------------------------------
    // times
    // ------------------------------------------------------------
    localparam int CTS_10_US = 10000;
    localparam int CTS_30_US = 30000;
    localparam int IDLE_A_US = 70000;
    localparam int IDLE_B_US = 7000;
    localparam int IDLE_C_US = 2000;
    localparam int IDLE_D_US = 700;
    localparam int IDLE_E_US = 150;
    localparam int TURN_B_US = 100;
    localparam int TURN_C_US = 1000;
    localparam int TURN_D_US = 5000;
    localparam int TURN_E_US = 35000;
    localparam int CTS_10_CYC = CTS_10_US * CLK_MHZ;
    localparam int CTS_30_CYC = CTS_30_US * CLK_MHZ;
    localparam int IDLE_A_CYC = IDLE_A_US * CLK_MHZ;
    localparam int IDLE_B_CYC = IDLE_B_US * CLK_MHZ;
    localparam int IDLE_C_CYC = IDLE_C_US * CLK_MHZ;
    localparam int IDLE_D_CYC = IDLE_D_US * CLK_MHZ;
    localparam int IDLE_E_CYC = IDLE_E_US * CLK_MHZ;
    localparam int TURN_B_CYC = TURN_B_US * CLK_MHZ;
    localparam int TURN_C_CYC = TURN_C_US * CLK_MHZ;
    localparam int TURN_D_CYC = TURN_D_US * CLK_MHZ;
    localparam int TURN_E_CYC = TURN_E_US * CLK_MHZ;
endpackage : rde_pkg

// ==== test/rde_line_peer.sv ====
// Purpose: far side of the converter: attached terminal leads and rs485 line
// Assumes: levels change only just after a rising pclk edge
// Notes: idle state is mark on both data lines, no leads, no carrier
`timescale 1ns/10ps
module rde_line_peer (
    input wire logic pclk,
    output logic rs232_rxd,
    output logic rts_in,
    output logic cd_in,
    output logic rs485_rxd,
    output logic rs485_carrier
);
    initial {rs232_rxd, rts_in, cd_in, rs485_rxd, rs485_carrier} = 5'h12;
    // ------------------------------------------------------------
    // line drive, order: rxd232 rts cd rxd485 carrier
    // ------------------------------------------------------------
    task automatic drive(input logic [4:0] v);
        @(posedge pclk);
        {rs232_rxd, rts_in, cd_in, rs485_rxd, rs485_carrier} <= v;
    endtask : drive
endmodule : rde_line_peer

// ==== test/rs485_driver_enable_control_tb.sv ====
// Purpose: self-checking bench of the line-driver enable controller
// Assumes: shortened delay parameters, settings written over apb
// Notes: delays counted in edges after the edge that launches the cause
`timescale 1ns/10ps
module rs485_driver_enable_control_tb;
    localparam int C10 = 20;
    localparam int C30 = 40;
    int cts_t[3] = '{0, C10, C30};
    int idl_t[5] = '{100, 80, 60, 40, 30};
    int trn_t[5] = '{0, 10, 20, 30, 50};
    int n_errors = 0;
    int checked = 0;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rs232_rxd, rts_in, cd_in, rs485_rxd, rs485_carrier;
    logic rs232_txd, cts_out, rs485_txd, rs485_de, rs485_re_n;
    wire logic [4:0] outs;
    assign outs = {rs485_re_n, rs485_de, cts_out, rs485_txd, rs232_txd};
    rde_ctrl #(.CTS_10_CYC(C10), .CTS_30_CYC(C30), .IDLE_A_CYC(100), .IDLE_B_CYC(80), .IDLE_C_CYC(60),
        .IDLE_D_CYC(40), .IDLE_E_CYC(30), .TURN_B_CYC(10), .TURN_C_CYC(20), .TURN_D_CYC(30), .TURN_E_CYC(50))
    u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rs232_rxd(rs232_rxd),
        .rts_in(rts_in), .cd_in(cd_in), .rs485_rxd(rs485_rxd), .rs485_carrier(rs485_carrier),
        .rs232_txd(rs232_txd), .cts_out(cts_out), .rs485_txd(rs485_txd), .rs485_de(rs485_de),
        .rs485_re_n(rs485_re_n));
    rde_line_peer u_peer (.pclk(pclk), .rs232_rxd(rs232_rxd), .rts_in(rts_in), .cd_in(cd_in),
        .rs485_rxd(rs485_rxd), .rs485_carrier(rs485_carrier));
    always #2 pclk = ~pclk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk_b(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask : chk_b
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_w
    task automatic chk_n(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi)
        begin
            n_errors++;
            $display("mismatch at %0t: %0d cycles, expected %0d to %0d", $time, got, lo, hi);
        end
    endtask : chk_n
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk_b(pready, 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] cf(input logic role, input logic [1:0] cts, input logic src,
        input logic [2:0] idl, input logic [2:0] trn, input logic [3:0] flg);
        cf = 32'h0;
        cf[rde_pkg::CFG_ROLE] = role;
        cf[rde_pkg::CFG_CTS_LO +: 2] = cts;
        cf[rde_pkg::CFG_SRC] = src;
        cf[rde_pkg::CFG_IDLE_LO +: 3] = idl;
        cf[rde_pkg::CFG_TURN_LO +: 3] = trn;
        cf[rde_pkg::CFG_DUPLEX +: 4] = flg;
    endfunction : cf
    task automatic wcfg(input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, rde_pkg::ADDR_CFG, d, r, e);
    endtask : wcfg
    task automatic cnt(input int i, input logic v, output int n);
        n = 0;
        #1;
        while (outs[i] !== v && n < 2000)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask : cnt
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        chk_b(rs232_txd, 1'b1);
        chk_b(rs485_de, 1'b0);
        apb(1'b0, rde_pkg::ADDR_CFG, 32'h0, r, e);
        chk_w(r, 32'h0);
        apb(1'b1, rde_pkg::ADDR_STAT, 32'hffff_ffff, r, e);
        apb(1'b0, rde_pkg::ADDR_STAT, 32'h0, r, e);
        chk_w(r, 32'h0);
        apb(1'b1, 8'h08, 32'h1, r, e);
        chk_b(e, 1'b1);
        apb(1'b1, rde_pkg::ADDR_CFG, 32'hffff_ffff, r, e);
        apb(1'b0, rde_pkg::ADDR_CFG, 32'h0, r, e);
        chk_w(r, 32'h0000_3fff);
        $display("test regs done");
    endtask : t_regs
    task automatic t_cts;
        int n;
        for (int i = 0; i < 3; i++)
        begin
            wcfg(cf(1'b1, 2'(i), 1'b0, 3'h0, 3'h0, 4'h0));
            u_peer.drive(5'h1a);
            cnt(2, 1'b1, n);
            chk_n(n, cts_t[i] + 2, cts_t[i] + 2);
            chk_b(rs485_de, 1'b1);
            u_peer.drive(5'h12);
            cnt(2, 1'b0, n);
            chk_n(n, 1, 1);
        end
        u_peer.drive(5'h1a);
        repeat (10) @(posedge pclk);
        u_peer.drive(5'h12);
        u_peer.drive(5'h1a);
        cnt(2, 1'b1, n);
        chk_n(n, C30 + 2, C30 + 2);
        u_peer.drive(5'h12);
        wcfg(cf(1'b1, rde_pkg::CTS_SEL_ON, 1'b1, 3'h0, 3'h0, 4'h0));
        u_peer.drive(5'h1a);
        cnt(2, 1'b1, n);
        chk_n(n, 1, 1);
        chk_b(rs485_de, 1'b1);
        u_peer.drive(5'h12);
        wcfg(cf(1'b0, rde_pkg::CTS_SEL_ON, 1'b0, 3'h0, 3'h0, 4'h1));
        repeat (3) @(posedge pclk);
        chk_b(rs485_de, 1'b1);
        chk_b(rs485_re_n, 1'b1);
        $display("test cts done");
    endtask : t_cts
    task automatic t_leads;
        int n;
        wcfg(cf(1'b1, rde_pkg::CTS_SEL_10, 1'b0, 3'h0, 3'h0, 4'h2));
        u_peer.drive(5'h1b);
        repeat (C10 + 10) @(posedge pclk);
        chk_b(cts_out, 1'b0);
        u_peer.drive(5'h12);
        wcfg(cf(1'b1, rde_pkg::CTS_SEL_10, 1'b0, 3'h0, 3'h0, 4'ha));
        u_peer.drive(5'h1a);
        repeat (C10 + 10) @(posedge pclk);
        chk_b(cts_out, 1'b0);
        u_peer.drive(5'h12);
        wcfg(cf(1'b0, rde_pkg::CTS_SEL_10, 1'b0, 3'h0, 3'h0, 4'h0));
        u_peer.drive(5'h1a);
        repeat (C10 + 10) @(posedge pclk);
        chk_b(cts_out, 1'b0);
        chk_b(rs485_de, 1'b0);
        u_peer.drive(5'h16);
        cnt(3, 1'b1, n);
        chk_n(n, 1, 1);
        wcfg(cf(1'b0, rde_pkg::CTS_SEL_10, 1'b1, 3'h0, 3'h0, 4'h0));
        repeat (3) @(posedge pclk);
        chk_b(rs485_de, 1'b0);
        u_peer.drive(5'h12);
        $display("test leads done");
    endtask : t_leads
    task automatic t_data;
        int n;
        for (int k = 0; k < 5; k++)
        begin
            wcfg(cf(1'b0, 2'h0, 1'b1, 3'(k), 3'h0, 4'h0));
            u_peer.drive(5'h02);
            cnt(3, 1'b1, n);
            chk_n(n, 2, 2);
            u_peer.drive(5'h12);
            repeat (idl_t[k] / 2) @(posedge pclk);
            u_peer.drive(5'h02);
            u_peer.drive(5'h12);
            cnt(3, 1'b0, n);
            chk_n(n, idl_t[k] + 1, idl_t[k] + 3);
        end
        $display("test data done");
    endtask : t_data
    task automatic t_turn;
        int n;
        for (int k = 0; k < 5; k++)
        begin
            wcfg(cf(1'b1, 2'h0, 1'b0, 3'h0, 3'(k), 4'h1));
            u_peer.drive(5'h1a);
            cnt(3, 1'b1, n);
            chk_b(rs485_re_n, 1'b1);
            u_peer.drive(5'h12);
            cnt(3, 1'b0, n);
            cnt(4, 1'b0, n);
            chk_n(n, trn_t[k], trn_t[k] + 1);
        end
        wcfg(cf(1'b1, 2'h0, 1'b0, 3'h0, 3'h4, 4'h0));
        u_peer.drive(5'h1a);
        cnt(3, 1'b1, n);
        chk_b(rs485_re_n, 1'b0);
        u_peer.drive(5'h12);
        $display("test turn done");
    endtask : t_turn
    task automatic t_route;
        int n;
        for (int m = 0; m < 2; m++)
        begin
            wcfg(cf(1'b0, 2'h0, 1'b0, 3'h0, 3'h0, m ? 4'h4 : 4'h0));
            u_peer.drive(5'h02);
            cnt(1 - m, 1'b0, n);
            chk_n(n, 1, 1);
            chk_b(outs[m], 1'b1);
            u_peer.drive(5'h10);
            cnt(m, 1'b0, n);
            chk_n(n, 1, 1);
            u_peer.drive(5'h12);
        end
        $display("test route done");
    endtask : t_route
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_cts();
        t_leads();
        t_data();
        t_turn();
        t_route();
        give_verdict();
    end
    initial
    begin
        #100000;
        n_errors++;
        give_verdict();
    end
endmodule : rs485_driver_enable_control_tb
